// ---- rtl/ars_dummy_never.v ----
// Purpose: none
`timescale 1ns/100ps

// ---- rtl/ars_regs.vh ----
// Purpose: Offsets, field positions, reset values and codes of the
//          axis homing block.
// Assumes: Included by its bare name from rtl/ design files.
// Notes:   Definitions only.
`ifndef ARS_REGS_VH
`define ARS_REGS_VH

// Register byte offsets on the APB slave
`define ARS_OFF_CMD      12'h000
`define ARS_OFF_MODE     12'h004
`define ARS_OFF_SVEL     12'h008
`define ARS_OFF_CVEL     12'h00C
`define ARS_OFF_DIST     12'h010
`define ARS_OFF_STOPEN   12'h014
`define ARS_OFF_STATUS   12'h018
`define ARS_OFF_CENTRE   12'h01C

// Command codes written to the command register
`define ARS_CMD_START    32'h0000_0000
`define ARS_CMD_STOP     32'h0000_0001
`define ARS_CMD_QUERY    32'h0000_0002

// Mode field: base value in low bits, swap and polarity flags above
`define ARS_MODE_SWAP    6
`define ARS_MODE_INV     7
`define ARS_BASE_MIN     6'h01
`define ARS_BASE_LAST_SW 6'h04
`define ARS_BASE_MAX     6'h08

// Status register field positions
`define ARS_ST_BUSY      0
`define ARS_ST_DONE      1
`define ARS_ST_MODE_ERR  2
`define ARS_ST_STATE_LO  8
`define ARS_ST_SW_LO     16

// Reset values
`define ARS_RST_MODE     8'h01
`define ARS_RST_SVEL     32'h0000_1000
`define ARS_RST_CVEL     32'h0000_0100
`define ARS_RST_STOPEN   2'h0

`endif

// ---- rtl/ars_search.v ----
// Purpose: Per-axis homing state machine with APB register access.
// Assumes: Switch inputs and ramp position synchronous to clk; the ramp
//          follows motion_run, motion_dir and motion_vel.
// Notes:   Notes on behaviour
// Notes on behaviour
// - Command register starts, aborts, or queries homing.
// - Auto-stop enables never affect the search.
// - Search velocity until first target switch detection.
// - Creep off, re-enter, origin at midpoint.
// - Calibration moves use calibration velocity.
// - Mode base 1 to 8 picks procedure.
// - Mode 1 homes on left switch only.
// - Mode 65 homes on right switch instead.
// - Mode 2 right switch, then left origin.
// - Mode 2 reports switch separation in microsteps.
// - Mode 66 left first, right origin.
// - Mode 3 right, then left switch centre.
// - Mode 3 reports right to left-centre distance.
// - Mode 67 left first, right centre origin.
// - Mode 4 and 68 centre single switch.
// - Mode 5 home negative, reverse at left.
// - Mode 6 home positive, reverse at right.
// - Mode 7 home positive, limits ignored.
// - Mode 8 home negative, limits ignored.
// - Adding 128 inverts home switch polarity.
// - Encoder counter cleared when homing finishes.
`timescale 1ns/100ps
`default_nettype none
`include "ars_regs.vh"

module ars_search (
    input  wire        clk,
    input  wire        rst,
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        sw_left,
    input  wire        sw_right,
    input  wire        sw_home,
    input  wire [31:0] position,
    output wire        motion_run,
    output reg         motion_dir,
    output reg  [31:0] motion_vel,
    output reg         zero_load,
    output reg  [31:0] zero_value,
    output reg         enc_clear,
    output wire        busy
);

    // One-hot states
    localparam [6:0] ST_IDLE    = 7'h01;
    localparam [6:0] ST_FAR     = 7'h02;
    localparam [6:0] ST_SEEK    = 7'h04;
    localparam [6:0] ST_LEAVE   = 7'h08;
    localparam [6:0] ST_REENTER = 7'h10;
    localparam [6:0] ST_CROSS   = 7'h20;
    localparam [6:0] ST_FINISH  = 7'h40;

    // Target switch select codes
    localparam [1:0] TGT_LEFT  = 2'h0;
    localparam [1:0] TGT_RIGHT = 2'h1;
    localparam [1:0] TGT_HOME  = 2'h2;

    reg  [6:0]  state;
    reg  [7:0]  mode_sel;
    reg  [7:0]  run_mode;
    reg  [31:0] search_vel;
    reg  [31:0] cal_vel;
    reg  [31:0] distance;
    reg  [1:0]  stop_enable;
    reg         done;
    reg         mode_err;
    reg         reversed;
    reg  [31:0] p_far;
    reg  [31:0] p_first;
    reg  [31:0] p_a;
    reg  [31:0] p_b;
    wire        l_act;
    wire        r_act;
    wire        h_act;

    // Distance without sign, for travel reports
    function [31:0] ars_absdiff;
        input [31:0] a;
        input [31:0] b;
        reg   [31:0] d;
        begin
            d = a - b;
            ars_absdiff = d[31] ? (~d + 32'h0000_0001) : d;
        end
    endfunction

    // APB decode; zero wait states
    wire        apb_wr   = psel & penable & pwrite;
    wire        apb_set  = psel & ~penable;
    wire        hit_cmd  = (paddr == `ARS_OFF_CMD);
    wire        hit_mode = (paddr == `ARS_OFF_MODE);
    wire        hit_svel = (paddr == `ARS_OFF_SVEL);
    wire        hit_cvel = (paddr == `ARS_OFF_CVEL);
    wire        hit_dist = (paddr == `ARS_OFF_DIST);
    wire        hit_sten = (paddr == `ARS_OFF_STOPEN);
    wire        hit_stat = (paddr == `ARS_OFF_STATUS);
    wire        hit_cent = (paddr == `ARS_OFF_CENTRE);
    wire        hit_any  = hit_cmd | hit_mode | hit_svel | hit_cvel |
                           hit_dist | hit_sten | hit_stat | hit_cent;
    wire        start_req = apb_wr & hit_cmd &
                            (pwdata == `ARS_CMD_START);
    wire        stop_req  = apb_wr & hit_cmd &
                            (pwdata == `ARS_CMD_STOP);

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // Mode in force: live setting while idle, latched copy while running
    wire [7:0]  cfg_mode = state[0] ? mode_sel : run_mode;
    wire [5:0]  base     = cfg_mode[5:0];
    wire        swap     = cfg_mode[`ARS_MODE_SWAP];
    wire        inv      = cfg_mode[`ARS_MODE_INV];
    wire        base_sw  = (base >= `ARS_BASE_MIN) &
                           (base <= `ARS_BASE_LAST_SW);
    wire        base_hm  = (base > `ARS_BASE_LAST_SW) &
                           (base <= `ARS_BASE_MAX);
    // Swap only for switch modes, polarity only for home modes
    wire        mode_ok  = (base_sw & ~inv) | (base_hm & ~swap);
    wire        two_stage = (base == 6'h02) | (base == 6'h03);
    wire        rev_en    = (base == 6'h05) | (base == 6'h06);

    // Target switch and seek direction, direction 1 is positive
    reg  [1:0]  tgt_sel;
    reg         seek_dir;
    always @* begin
        tgt_sel  = TGT_LEFT;
        seek_dir = 1'b0;
        case (base)
            6'h01, 6'h02, 6'h03, 6'h04: begin
                tgt_sel  = swap ? TGT_RIGHT : TGT_LEFT;
                seek_dir = swap;
            end
            6'h05: begin
                tgt_sel  = TGT_HOME;
                seek_dir = 1'b0;
            end
            6'h06, 6'h07: begin
                tgt_sel  = TGT_HOME;
                seek_dir = 1'b1;
            end
            6'h08: begin
                tgt_sel  = TGT_HOME;
                seek_dir = 1'b0;
            end
            default: begin
                tgt_sel  = TGT_LEFT;
                seek_dir = 1'b0;
            end
        endcase
    end

    // Switch inputs; only the home input takes the polarity flag
    ars_swin u_left (
        .clk    (clk),
        .rst    (rst),
        .raw    (sw_left),
        .invert (1'b0),
        .active (l_act)
    );

    ars_swin u_right (
        .clk    (clk),
        .rst    (rst),
        .raw    (sw_right),
        .invert (1'b0),
        .active (r_act)
    );

    ars_swin u_home (
        .clk    (clk),
        .rst    (rst),
        .raw    (sw_home),
        .invert (inv & base_hm),
        .active (h_act)
    );

    // Auto-stop enables never enter these terms
    wire tgt_act = (tgt_sel == TGT_HOME)  ? h_act :
                   (tgt_sel == TGT_RIGHT) ? r_act : l_act;
    // First-stage switch lies opposite the target
    wire far_act = swap ? l_act : r_act;
    wire far_dir = ~swap;
    // Limit in the current travel direction, used by reversing modes
    wire lim_act = motion_dir ? r_act : l_act;

    // Midpoint of the two calibrated switching points
    wire [32:0] pair_sum = {p_a[31], p_a} + {p_b[31], p_b};
    wire [31:0] centre   = pair_sum[32:1];

    assign busy       = ~state[0];
    assign motion_run = ~state[0] & ~state[6];

    // Homing state machine; abort wins over any progress
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= ST_IDLE;
            run_mode   <= 8'h00;
            motion_dir <= 1'b0;
            reversed   <= 1'b0;
            done       <= 1'b0;
            mode_err   <= 1'b0;
            p_far      <= 32'h0000_0000;
            p_first    <= 32'h0000_0000;
            p_a        <= 32'h0000_0000;
            p_b        <= 32'h0000_0000;
            distance   <= 32'h0000_0000;
            zero_load  <= 1'b0;
            zero_value <= 32'h0000_0000;
            enc_clear  <= 1'b0;
        end else begin
            zero_load <= 1'b0;
            enc_clear <= 1'b0;
            if (stop_req && busy) begin
                state <= ST_IDLE;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (start_req && mode_ok) begin
                            run_mode   <= mode_sel;
                            done       <= 1'b0;
                            mode_err   <= 1'b0;
                            reversed   <= 1'b0;
                            motion_dir <= two_stage ? far_dir : seek_dir;
                            state      <= two_stage ? ST_FAR : ST_SEEK;
                        end else if (start_req) begin
                            mode_err <= 1'b1;
                        end
                    end
                    ST_FAR: begin
                        if (far_act) begin
                            p_far      <= position;
                            motion_dir <= seek_dir;
                            state      <= ST_SEEK;
                        end
                    end
                    ST_SEEK: begin
                        if (tgt_act) begin
                            p_first <= position;
                            state   <= ST_LEAVE;
                        end else if (rev_en && lim_act && !reversed) begin
                            motion_dir <= ~motion_dir;
                            reversed   <= 1'b1;
                        end
                    end
                    ST_LEAVE: begin
                        if (!tgt_act) begin
                            motion_dir <= ~motion_dir;
                            state      <= ST_REENTER;
                        end
                    end
                    ST_REENTER: begin
                        if (tgt_act) begin
                            p_a   <= position;
                            state <= ST_CROSS;
                        end
                    end
                    ST_CROSS: begin
                        if (!tgt_act) begin
                            p_b   <= position;
                            state <= ST_FINISH;
                        end
                    end
                    ST_FINISH: begin
                        zero_value <= position - centre;
                        zero_load  <= 1'b1;
                        enc_clear  <= 1'b1;
                        done       <= 1'b1;
                        if (base == 6'h02) begin
                            distance <= ars_absdiff(p_far, p_first);
                        end else if (base == 6'h03) begin
                            distance <= ars_absdiff(p_far, centre);
                        end
                        state <= ST_IDLE;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Velocity to the ramp; one cycle behind the state on purpose
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            motion_vel <= 32'h0000_0000;
        end else if (state[3] | state[4] | state[5]) begin
            motion_vel <= cal_vel;
        end else if (state[1] | state[2]) begin
            motion_vel <= search_vel;
        end else begin
            motion_vel <= 32'h0000_0000;
        end
    end

    // Writable settings
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_sel    <= `ARS_RST_MODE;
            search_vel  <= `ARS_RST_SVEL;
            cal_vel     <= `ARS_RST_CVEL;
            stop_enable <= `ARS_RST_STOPEN;
        end else if (apb_wr) begin
            if (hit_mode) begin
                mode_sel <= pwdata[7:0];
            end
            if (hit_svel) begin
                search_vel <= pwdata;
            end
            if (hit_cvel) begin
                cal_vel <= pwdata;
            end
            // Held for software only, the search never looks at it
            if (hit_sten) begin
                stop_enable <= pwdata[1:0];
            end
        end
    end

    // Read data captured in the setup phase, stable through access
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (apb_set && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit_cmd) begin
                prdata <= {31'h0000_0000, busy};
            end
            if (hit_mode) begin
                prdata <= {24'h00_0000, mode_sel};
            end
            if (hit_svel) begin
                prdata <= search_vel;
            end
            if (hit_cvel) begin
                prdata <= cal_vel;
            end
            if (hit_dist) begin
                prdata <= distance;
            end
            if (hit_sten) begin
                prdata <= {30'h0000_0000, stop_enable};
            end
            if (hit_stat) begin
                prdata <= {13'h0000, h_act, r_act, l_act,
                           1'b0, state, 5'h00,
                           mode_err, done, busy};
            end
            if (hit_cent) begin
                prdata <= centre;
            end
        end
    end

endmodule // ars_search

`default_nettype wire

// ---- rtl/ars_swin.v ----
// Purpose: Registers one switch input with selectable active polarity.
// Assumes: Input is synchronous to clk.
// Notes:   Output is high while the switch counts as active.
`timescale 1ns/100ps
`default_nettype none

module ars_swin (
    input  wire clk,
    input  wire rst,
    input  wire raw,
    input  wire invert,
    output reg  active
);

    // One flop; polarity applied before it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            active <= 1'b0;
        end else begin
            active <= raw ^ invert;
        end
    end

endmodule // ars_swin

`default_nettype wire

// ---- tb/ars_chk.sv ----
// Purpose: Port checks for the axis homing block.
// Assumes: APB writes land at psel, penable and pwrite high.
// Notes:   Mirrors mode and search velocity to predict starts.
`timescale 1ns/100ps
`default_nettype none
`include "ars_regs.vh"
module ars_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        motion_run,
    input wire logic        motion_dir,
    input wire logic [31:0] motion_vel,
    input wire logic        zero_load,
    input wire logic        enc_clear,
    input wire logic        busy
);
    logic [7:0]  mode_q;
    logic [31:0] svel_q;
    // Start decode and mode validity
    wire         wr = psel && penable && pwrite;
    wire         cmd = wr && paddr == `ARS_OFF_CMD;
    wire         go = cmd && pwdata == `ARS_CMD_START && !busy;
    wire [5:0]   base = mode_q[5:0];
    wire         ok_sw = base >= `ARS_BASE_MIN && base <= `ARS_BASE_LAST_SW;
    wire         ok_hm = base > `ARS_BASE_LAST_SW && base <= `ARS_BASE_MAX;
    wire         ok = ok_sw && !mode_q[7] || ok_hm && !mode_q[6];
    wire         far = base == 6'h02 || base == 6'h03;
    wire         e_dir = ok_hm ? base == 6'h06 || base == 6'h07 : mode_q[6] ^ far;
    // Shadow of the registers the checks depend on
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= `ARS_RST_MODE;
            svel_q <= `ARS_RST_SVEL;
        end else if (wr) begin
            if (paddr == `ARS_OFF_MODE)
                mode_q <= pwdata[7:0];
            if (paddr == `ARS_OFF_SVEL)
                svel_q <= pwdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_start_runs: assert property (go && ok |=> busy && motion_run)
        else $error("valid start did not begin homing");
    a_bad_mode: assert property (go && !ok |=> !busy [*3])
        else $error("invalid mode started homing");
    a_first_dir: assert property (go && ok |=> motion_dir == e_dir)
        else $error("wrong first direction");
    a_search_vel: assert property ($rose(busy) |-> ##1 motion_vel == svel_q)
        else $error("search velocity not used");
    a_run_busy: assert property (motion_run |-> busy)
        else $error("motion while idle");
    a_idle_still: assert property (!busy && !$past(busy) |->
        motion_vel == 32'h0 && !motion_run)
        else $error("idle axis not at rest");
    a_clear_pair: assert property (zero_load == enc_clear)
        else $error("encoder clear not paired with zero load");
    a_zero_end: assert property (zero_load |-> !busy && $past(busy)
        ##1 !zero_load)
        else $error("zero load outside end of run");
    a_stop_abort: assert property (cmd && pwdata == `ARS_CMD_STOP && busy
        |=> !busy && !motion_run && !zero_load)
        else $error("abort did not stop the axis");
    a_err_unmap: assert property (psel && penable |-> pslverr ==
        (paddr > `ARS_OFF_CENTRE || paddr[1:0] != 2'h0))
        else $error("slave error wrong");
    cover property (zero_load);
    cover property (cmd && pwdata == `ARS_CMD_STOP && busy);
    cover property (go && !ok);
endmodule // ars_chk
bind ars_search ars_chk ars_chk_inst (.*);
`default_nettype wire

// ---- tb/ars_part.sv ----
// Purpose: Switches and ramp on the far side of the homing block.
// Assumes: One microstep per cycle while motion_run is high.
// Notes:   Windows fixed in absolute steps; jam holds both ends on.
`timescale 1ns/100ps
`default_nettype none
module ars_part (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        motion_run,
    input  wire logic        motion_dir,
    input  wire logic [31:0] motion_vel,
    input  wire logic        zero_load,
    input  wire logic [31:0] zero_value,
    input  wire logic        jam,
    input  wire logic        home_low,
    output logic      [31:0] position,
    output logic             sw_left,
    output logic             sw_right,
    output logic             sw_home,
    output logic      [31:0] origin,
    output logic      [31:0] last_vel
);
    logic signed [31:0] abs_pos;
    // Ramp steps each cycle while motion_run is high; zero load moves the origin only
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            abs_pos <= 32'sh0;
            origin <= 32'h0;
            last_vel <= 32'h0;
        end else begin
            if (motion_run) begin
                abs_pos <= motion_dir ? abs_pos + 1 : abs_pos - 1;
                last_vel <= motion_vel;
            end
            if (zero_load)
                origin <= abs_pos - zero_value;
        end
    end
    assign position = abs_pos - origin;
    // Finite windows, so leaving works in either direction
    assign sw_left = jam || abs_pos inside {[-49:-40]};
    assign sw_right = jam || abs_pos inside {[40:49]};
    assign sw_home = home_low ^ (abs_pos inside {[10:19]});
endmodule // ars_part
`default_nettype wire

// ---- tb/ars_search_tb.sv ----
// Purpose: Self-checking bench for the axis homing block.
// Assumes: Partner steps once per cycle; pready answers promptly.
// Notes:   Origins allow a few steps for switch input lag.
`timescale 1ns/100ps
`default_nettype none
`include "ars_regs.vh"
module ars_search_tb;
    typedef struct {logic [31:0] m; int lo; int hi;} ars_exp_t;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, jam = 1'b0, home_low = 1'b0, zl_q = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, position, motion_vel, zero_value;
    logic [31:0] origin, last_vel;
    logic        pready, pslverr, sw_left, sw_right, sw_home, busy;
    logic        motion_run, motion_dir, zero_load, enc_clear;
    int          checked = 0, miscompares = 0, seed = 94, svel, cvel;
    ars_exp_t    rdq[$], orq[$];
    logic [7:0]  md [13] = '{8'h01, 8'h41, 8'h02, 8'h42, 8'h03,
        8'h43, 8'h06, 8'h08, 8'h04, 8'h05, 8'h07, 8'h85, 8'h44};
    int          ctr [13] = '{-44, 44, -44, 44, -44, 44, 14, 14, -44, 14,
        14, 14, 44};
    logic [7:0]  bad [5] = '{8'h09, 8'h00, 8'h48, 8'h81, 8'hC5};

    ars_search ars_search_inst (.*);
    ars_part ars_part_inst (.*);

    always #20 clk = ~clk;

    task automatic cmp(input logic [31:0] v, input ars_exp_t e);
        logic signed [31:0] s;
        s = v & e.m;
        checked++;
        if ((^s === 1'bx) || s < e.lo || s > e.hi) begin
            miscompares++;
            $display("FAIL %0t got %0d want %0d..%0d", $time, s, e.lo, e.hi);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m, input int lo, input int hi);
        rdq.push_back('{m, lo, hi});
        apb(a, 1'b0, 32'h0);
    endtask

    task automatic home(input logic [7:0] m, input int c);
        apb(`ARS_OFF_MODE, 1'b1, {24'h0, m});
        orq.push_back('{32'hFFFF_FFFF, c - 4, c + 4});
        apb(`ARS_OFF_CMD, 1'b1, `ARS_CMD_START);
        while (busy !== 1'b0)
            @(posedge clk);
        repeat (3) @(posedge clk);
        $display("test mode %0d done", m);
    endtask

    task automatic tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Result watcher: read data and origin loads against the notes
    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready === 1'b1)
            cmp(prdata, rdq.pop_front());
        if (zl_q) begin
            cmp(last_vel, '{32'hFFFF_FFFF, cvel, cvel});
            if (orq.size() == 0)
                cmp(32'h1, '{32'hFFFF_FFFF, 0, 0});
            else
                cmp(origin, orq.pop_front());
        end
        zl_q <= zero_load;
    end

    // Hang guard, well past the expected run length
    initial begin
        #2000000;
        miscompares++;
        $display("FAIL %0t watchdog expired", $time);
        tally_and_finish;
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`ARS_OFF_MODE, 32'hFF, 1, 1);
        rd(`ARS_OFF_SVEL, 32'hFFFF_FFFF, 'h1000, 'h1000);
        rd(`ARS_OFF_CVEL, 32'hFFFF_FFFF, 'h100, 'h100);
        rd(`ARS_OFF_STOPEN, 32'h3, 0, 0);
        rd(`ARS_OFF_STATUS, 32'h7F07, 'h100, 'h100);
        rd(12'h020, 32'hFFFF_FFFF, 0, 0);
        $display("test reset values done");
        svel = ($random(seed) & 32'h0000_FFFF) + 1;
        cvel = ($random(seed) & 32'h0000_0FFF) + 1;
        apb(`ARS_OFF_SVEL, 1'b1, svel);
        apb(`ARS_OFF_CVEL, 1'b1, cvel);
        apb(`ARS_OFF_STOPEN, 1'b1, 32'h3);
        for (int i = 0; i < 13; i++) begin
            jam <= md[i] == 8'h07 || md[i] == 8'h08;
            home_low <= md[i][7];
            home(md[i], ctr[i]);
            if (i == 0)
                rd(`ARS_OFF_DIST, 32'hFFFF_FFFF, 0, 0);
            if (i inside {[2:5]})
                rd(`ARS_OFF_DIST, 32'hFFFF_FFFF, 78, 92);
        end
        apb(`ARS_OFF_MODE, 1'b1, 32'h04);
        apb(`ARS_OFF_CMD, 1'b1, `ARS_CMD_START);
        apb(`ARS_OFF_CMD, 1'b1, `ARS_CMD_QUERY);
        rd(`ARS_OFF_CMD, 32'h1, 1, 1);
        apb(`ARS_OFF_CMD, 1'b1, `ARS_CMD_STOP);
        rd(`ARS_OFF_STATUS, 32'h3, 0, 0);
        repeat (20) @(posedge clk);
        $display("test abort done");
        foreach (bad[i]) begin
            apb(`ARS_OFF_MODE, 1'b1, {24'h0, bad[i]});
            apb(`ARS_OFF_CMD, 1'b1, `ARS_CMD_START);
            rd(`ARS_OFF_STATUS, 32'h5, 4, 4);
        end
        $display("test bad modes done");
        tally_and_finish;
    end
endmodule // ars_search_tb
`default_nettype wire
